//--- amsc_pkg.sv
// Shared constants and types of the asynchronous memory space controller
`default_nettype none
package amsc_pkg;
	// Register byte addresses
	localparam logic [31:0] AMSC_BCR_OFS = 32'hfffc0004;
	localparam logic [31:0] AMSC_WCR_OFS = 32'hfffc0028;
	// Bus control register fields
	localparam int AMSC_IDLE_LSB = 28;
	localparam int AMSC_TYPE_LSB = 12;
	localparam int AMSC_WIDTH_LSB = 9;
	localparam int AMSC_ENDIAN_BIT = 8;
	// Wait control register fields
	localparam int AMSC_BCOUNT_LSB = 20;
	localparam int AMSC_BWAIT_LSB = 16;
	localparam int AMSC_SETUP_LSB = 11;
	localparam int AMSC_WR_LSB = 7;
	localparam int AMSC_XMASK_BIT = 6;
	localparam int AMSC_HOLD_LSB = 0;
	// Writable bits (type, bus size and endian bit are handled separately)
	localparam logic [31:0] AMSC_BCR_WMASK = 32'h7000_0000;
	localparam logic [31:0] AMSC_WCR_WMASK = 32'h0033_1fc3;
	// Reset values
	localparam logic [31:0] AMSC_BCR_RST = 32'h3000_0000;
	localparam logic [31:0] AMSC_WCR_RST = 32'h0000_0500;
	// Memory kind codes
	localparam logic [2:0] AMSC_TYPE_NORMAL = 3'h0;
	localparam logic [2:0] AMSC_TYPE_BURST = 3'h1;
	// Bus size codes
	localparam logic [1:0] AMSC_WIDTH_16 = 2'h2;
	localparam logic [1:0] AMSC_WIDTH_32 = 2'h3;
	// Half-cycle edge delays rounded up to whole bus cycles
	localparam logic [7:0] AMSC_HALF_ROUND = 8'h01;
	localparam logic [7:0] AMSC_BURST_EDGE = 8'h01;
	localparam int AMSC_TMR_W = 8;
	localparam int AMSC_BEAT_W = 5;

	typedef enum logic [2:0] {
		AMSC_S_IDLE = 3'b000,
		AMSC_S_SETUP = 3'b001,
		AMSC_S_STRB = 3'b010,
		AMSC_S_HOLD = 3'b011,
		AMSC_S_GAP = 3'b100
	} amsc_state_e;

	// Transfers in one burst page read
	function automatic logic [AMSC_BEAT_W-1:0] amsc_burst_beats(input logic [1:0] cnt_sel);
		unique case (cnt_sel)
			2'h0: amsc_burst_beats = 5'h04;
			2'h1: amsc_burst_beats = 5'h08;
			2'h2: amsc_burst_beats = 5'h08;
			2'h3: amsc_burst_beats = 5'h10;
		endcase
	endfunction

	// First-access wait cycles in burst mode; code 0111 and above skip one count
	function automatic logic [7:0] amsc_first_wait(input logic [3:0] w);
		amsc_first_wait = (w >= 4'h7) ? {4'h0, w} + 8'h01 : {4'h0, w};
	endfunction
endpackage
`default_nettype wire

//--- amsc_tmr_if.sv
// Load and expiry signals between the controller and its phase timer
`default_nettype none
interface amsc_tmr_if;
	logic load;
	logic [7:0] value;
	logic expired;
	modport ctrl (output load, output value, input expired);
	modport tmr (input load, input value, output expired);
endinterface
`default_nettype wire

//--- amsc_phase_timer.sv
// Down counter that times each bus phase
`default_nettype none
module amsc_phase_timer
	import amsc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Controller side
	amsc_tmr_if.tmr t
);
	logic [AMSC_TMR_W-1:0] cnt_q;

	always_ff @(posedge clk) begin
		if (srst) begin
			cnt_q <= '0;
		end else if (t.load) begin
			cnt_q <= t.value;
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - 8'h01;
		end
	end

	// A load of n keeps the phase for n+1 cycles.
	// Expiry never looks at the load, since the load itself is decided from expiry.
	assign t.expired = (cnt_q == '0);
endmodule // amsc_phase_timer
`default_nettype wire

//--- amsc_ctrl.sv
// External memory space controller for one chip-select space
`default_nettype none
module amsc_ctrl
	import amsc_pkg::*;
#(
	parameter int SPACE_ID = 0,
	parameter int AW = 24
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Strap and pin function selects
	input wire logic boot_width_strap,
	input wire logic pin_fn_addr_hi,
	input wire logic pin_fn_write_strobe,
	// Register port
	input wire logic [31:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Access request from the core
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_write,
	input wire logic [AW-1:0] req_addr,
	input wire logic [31:0] req_wdata,
	output logic rsp_valid,
	output logic [31:0] rsp_rdata,
	// Memory pins
	output logic space_zero_select_n,
	output logic read_strobe_n,
	output logic write_strobe_lane_n,
	output logic write_strobe_lane_oe,
	output logic [AW-1:0] mem_addr,
	output logic [AW-1:0] mem_addr_oe,
	output logic [31:0] mem_data_o,
	output logic mem_data_oe,
	input wire logic [31:0] mem_data_i,
	input wire logic ext_wait_req
);
	localparam bit BURST_OK = (SPACE_ID == 0) || (SPACE_ID == 4);
	localparam bit ENDIAN_OK = (SPACE_ID != 0);
	localparam bit WIDTH_RW = (SPACE_ID != 0);
	localparam int HI_PINS = 3;

	amsc_state_e state_q, state_d;
	logic [31:0] bcr_q, wcr_q, rdata_q, wdata_q, dout_q;
	logic [AW-1:0] base_q, pin_addr_q;
	logic [AMSC_BEAT_W-1:0] beat_q, beat_d, nbeats_q;
	logic write_q, burst_q, wide_q, little_q, rsp_q;
	logic cs_q, rd_q, wr_q, doe_q;

	amsc_tmr_if tmr ();
	amsc_phase_timer u_tmr (
		.clk(clk),
		.srst(srst),
		.t(tmr)
	);

	// Register field decode
	wire sel_bcr = (reg_addr == AMSC_BCR_OFS);
	wire sel_wcr = (reg_addr == AMSC_WCR_OFS);
	wire [2:0] idle_f = bcr_q[AMSC_IDLE_LSB +: 3];
	wire [2:0] mem_type = bcr_q[AMSC_TYPE_LSB +: 3];
	wire [1:0] width_f = bcr_q[AMSC_WIDTH_LSB +: 2];
	wire little_sel = ENDIAN_OK && bcr_q[AMSC_ENDIAN_BIT];
	wire [1:0] setup_f = wcr_q[AMSC_SETUP_LSB +: 2];
	wire [3:0] wr_f = wcr_q[AMSC_WR_LSB +: 4];
	wire xmask_f = wcr_q[AMSC_XMASK_BIT];
	wire [1:0] hold_f = wcr_q[AMSC_HOLD_LSB +: 2];
	wire [1:0] bcount_f = wcr_q[AMSC_BCOUNT_LSB +: 2];
	wire [1:0] bwait_f = wcr_q[AMSC_BWAIT_LSB +: 2];
	wire is_burst = BURST_OK && (mem_type == AMSC_TYPE_BURST);
	wire is_wide = (width_f == AMSC_WIDTH_32);

	// A kind write is taken only for a kind this space supports
	wire [2:0] type_new = reg_wdata[AMSC_TYPE_LSB +: 3];
	wire type_ok = (type_new == AMSC_TYPE_NORMAL) || (BURST_OK && type_new == AMSC_TYPE_BURST);
	wire [31:0] bcr_mask = AMSC_BCR_WMASK
		| (type_ok ? (32'h7 << AMSC_TYPE_LSB) : 32'h0)
		| (WIDTH_RW ? (32'h3 << AMSC_WIDTH_LSB) : 32'h0)
		| (ENDIAN_OK ? (32'h1 << AMSC_ENDIAN_BIT) : 32'h0);
	wire [31:0] bcr_wr_val = (bcr_q & ~bcr_mask) | (reg_wdata & bcr_mask);
	wire [31:0] wcr_wr_val = (wcr_q & ~AMSC_WCR_WMASK) | (reg_wdata & AMSC_WCR_WMASK);

	// Phase lengths, as timer loads (cycles minus one)
	wire [7:0] setup_ld = burst_q ? AMSC_BURST_EDGE - 8'h01
		: {6'h0, setup_f} + AMSC_HALF_ROUND - 8'h01;
	wire [7:0] hold_ld = burst_q ? AMSC_BURST_EDGE - 8'h01
		: {6'h0, hold_f} + AMSC_HALF_ROUND - 8'h01;
	wire [7:0] first_ld = burst_q ? amsc_first_wait(wr_f) : {4'h0, wr_f};
	wire [7:0] beat_ld = {6'h0, bwait_f};
	wire [7:0] gap_ld = {5'h0, idle_f} - 8'h01;

	// External wait stretches the strobe only when not masked
	wire stall = !xmask_f && ext_wait_req;
	wire strb_done = (state_q == AMSC_S_STRB) && tmr.expired && !stall;
	wire last_beat = (beat_q == nbeats_q - 5'h01);
	wire all_done = (beat_q == nbeats_q);
	wire idle_after = write_q && (idle_f != 3'h0);
	wire start = req_valid && req_ready;

	assign req_ready = (state_q == AMSC_S_IDLE);

	// Next state and timer load
	always_comb begin
		state_d = state_q;
		beat_d = beat_q;
		tmr.load = 1'b0;
		tmr.value = 8'h00;
		unique case (state_q)
			AMSC_S_IDLE: begin
				if (start) begin
					state_d = AMSC_S_SETUP;
					beat_d = '0;
					tmr.load = 1'b1;
					tmr.value = is_burst && !req_write ? AMSC_BURST_EDGE - 8'h01
						: {6'h0, setup_f} + AMSC_HALF_ROUND - 8'h01;
				end
			end
			AMSC_S_SETUP: begin
				if (tmr.expired) begin
					state_d = AMSC_S_STRB;
					tmr.load = 1'b1;
					tmr.value = first_ld;
				end
			end
			AMSC_S_STRB: begin
				if (strb_done) begin
					if (burst_q && !last_beat) begin
						// Page beats keep select and read strobe low
						beat_d = beat_q + 5'h01;
						tmr.load = 1'b1;
						tmr.value = beat_ld;
					end else begin
						state_d = AMSC_S_HOLD;
						tmr.load = 1'b1;
						tmr.value = hold_ld;
					end
				end
			end
			AMSC_S_HOLD: begin
				if (tmr.expired) begin
					beat_d = beat_q + 5'h01;
					tmr.load = 1'b1;
					if (idle_after) begin
						state_d = AMSC_S_GAP;
						tmr.value = gap_ld;
					end else if (last_beat) begin
						state_d = AMSC_S_IDLE;
					end else begin
						state_d = AMSC_S_SETUP;
						tmr.value = setup_ld;
					end
				end
			end
			AMSC_S_GAP: begin
				if (tmr.expired) begin
					state_d = all_done ? AMSC_S_IDLE : AMSC_S_SETUP;
					tmr.load = !all_done;
					tmr.value = setup_ld;
				end
			end
			default: begin
				state_d = AMSC_S_IDLE;
			end
		endcase
	end

	// Pin address of the coming beat; narrow bus steps by halfwords
	wire [AW-1:0] beat_ofs = wide_q ? AW'({beat_d, 2'b00}) : AW'({beat_d, 1'b0});
	wire [AW-1:0] base_sel = (state_q == AMSC_S_IDLE) ? req_addr : base_q;
	wire wide_sel = (state_q == AMSC_S_IDLE) ? is_wide : wide_q;
	wire [AW-1:0] beat_ofs_sel = (state_q == AMSC_S_IDLE) ? '0 : beat_ofs;
	wire [AW-1:0] raw_addr = base_sel + beat_ofs_sel;
	wire [AW-1:0] next_addr = wide_sel ? {raw_addr[AW-1:2], 2'b00}
		: {raw_addr[AW-1:1], 1'b0};

	// Lane order: big-endian puts the high half at the lower address
	wire [31:0] wsrc = (state_q == AMSC_S_IDLE) ? req_wdata : wdata_q;
	wire little_now = (state_q == AMSC_S_IDLE) ? little_sel : little_q;
	wire hi_first = (beat_d[0] == little_now);
	wire [31:0] next_dout = wide_sel ? wsrc : {16'h0, hi_first ? wsrc[31:16] : wsrc[15:0]};
	wire rd_hi = (beat_q[0] == little_q);
	wire word_end = wide_q || beat_q[0];

	wire act_d = (state_d == AMSC_S_SETUP) || (state_d == AMSC_S_STRB) || (state_d == AMSC_S_HOLD);
	wire wr_now = (state_q == AMSC_S_IDLE) ? req_write : write_q;

	// Configuration registers; strap sampled during reset
	always_ff @(posedge clk) begin
		if (srst) begin
			bcr_q <= AMSC_BCR_RST;
			bcr_q[AMSC_WIDTH_LSB +: 2] <= boot_width_strap ? AMSC_WIDTH_32 : AMSC_WIDTH_16;
			wcr_q <= AMSC_WCR_RST;
		end else if (reg_wr && sel_bcr) begin
			bcr_q <= bcr_wr_val;
		end else if (reg_wr && sel_wcr) begin
			wcr_q <= wcr_wr_val;
		end
	end

	// Read data stands in the cycle after the read strobe only
	always_ff @(posedge clk) begin
		if (srst) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			reg_rdata <= sel_bcr ? bcr_q : (sel_wcr ? wcr_q : 32'h0);
		end else begin
			reg_rdata <= '0;
		end
	end

	// Access context latched at the start of a request
	always_ff @(posedge clk) begin
		if (srst) begin
			base_q <= '0;
			wdata_q <= '0;
			write_q <= 1'b0;
			burst_q <= 1'b0;
			wide_q <= 1'b0;
			little_q <= 1'b0;
			nbeats_q <= '0;
		end else if (start) begin
			base_q <= req_addr;
			wdata_q <= req_wdata;
			write_q <= req_write;
			burst_q <= is_burst && !req_write;
			wide_q <= is_wide;
			little_q <= little_sel;
			if (is_burst && !req_write) begin
				nbeats_q <= amsc_burst_beats(bcount_f);
			end else begin
				nbeats_q <= is_wide ? 5'h01 : 5'h02;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state_q <= AMSC_S_IDLE;
			beat_q <= '0;
		end else begin
			state_q <= state_d;
			beat_q <= beat_d;
		end
	end

	// Read data assembly and answer pulse
	always_ff @(posedge clk) begin
		if (srst) begin
			rdata_q <= '0;
			rsp_q <= 1'b0;
		end else begin
			rsp_q <= 1'b0;
			if (strb_done && !write_q) begin
				if (wide_q) begin
					rdata_q <= mem_data_i;
				end else if (rd_hi) begin
					rdata_q[31:16] <= mem_data_i[15:0];
				end else begin
					rdata_q[15:0] <= mem_data_i[15:0];
				end
				rsp_q <= word_end;
			end else if (write_q && state_q == AMSC_S_HOLD && tmr.expired && last_beat) begin
				rsp_q <= 1'b1;
			end
		end
	end

	// Registered pin drive
	always_ff @(posedge clk) begin
		if (srst) begin
			cs_q <= 1'b0;
			rd_q <= 1'b0;
			wr_q <= 1'b0;
			doe_q <= 1'b0;
			pin_addr_q <= '0;
			dout_q <= '0;
		end else begin
			cs_q <= act_d;
			rd_q <= (state_d == AMSC_S_STRB) && !wr_now;
			wr_q <= (state_d == AMSC_S_STRB) && wr_now;
			doe_q <= act_d && wr_now;
			if (state_d == AMSC_S_SETUP || (burst_q && state_d == AMSC_S_STRB)) begin
				pin_addr_q <= next_addr;
				dout_q <= next_dout;
			end
		end
	end

	assign rsp_valid = rsp_q;
	assign rsp_rdata = rdata_q;
	assign space_zero_select_n = !cs_q;
	assign read_strobe_n = !rd_q;
	assign write_strobe_lane_n = !wr_q;
	assign write_strobe_lane_oe = pin_fn_write_strobe;
	assign mem_addr = pin_addr_q;
	assign mem_addr_oe = {{HI_PINS{pin_fn_addr_hi}}, {(AW-HI_PINS){1'b1}}};
	assign mem_data_o = dout_q;
	assign mem_data_oe = doe_q;
endmodule // amsc_ctrl
`default_nettype wire

//--- amsc_ctrl_props.sv
// Checker for register and memory pin timing of the memory space controller
`default_nettype none
module amsc_ctrl_props
	import amsc_pkg::*;
#(
	parameter int AW = 24
) (
	// Clock, reset and straps
	input wire logic clk,
	input wire logic srst,
	input wire logic boot_width_strap,
	input wire logic pin_fn_addr_hi,
	input wire logic pin_fn_write_strobe,
	// Register port
	input wire logic [31:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	// Memory pins
	input wire logic space_zero_select_n,
	input wire logic read_strobe_n,
	input wire logic write_strobe_lane_n,
	input wire logic write_strobe_lane_oe,
	input wire logic [AW-1:0] mem_addr,
	input wire logic [AW-1:0] mem_addr_oe,
	input wire logic mem_data_oe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	logic [31:0] bcr_q;
	logic [31:0] wcr_q;
	logic strap_q;
	logic wbeat_q;
	wire strb_n = read_strobe_n & write_strobe_lane_n;
	wire nrm = bcr_q[14:12] == AMSC_TYPE_NORMAL;
	wire bcr_rd = reg_rd && reg_addr == AMSC_BCR_OFS;
	// Own mirror of the timing fields, so a wrong register cannot hide a wrong timing
	always_ff @(posedge clk) begin
		if (srst) begin
			bcr_q <= AMSC_BCR_RST;
			wcr_q <= AMSC_WCR_RST;
			strap_q <= boot_width_strap;
		end else if (reg_wr && reg_addr == AMSC_BCR_OFS) begin
			bcr_q[30:28] <= reg_wdata[30:28];
			if (reg_wdata[14:12] <= AMSC_TYPE_BURST) bcr_q[14:12] <= reg_wdata[14:12];
		end else if (reg_wr && reg_addr == AMSC_WCR_OFS) begin
			wcr_q <= reg_wdata & AMSC_WCR_WMASK;
		end
	end
	// Set by a write beat, cleared by a read beat
	always_ff @(posedge clk) begin
		if (srst || !read_strobe_n) wbeat_q <= 1'b0;
		else if (!write_strobe_lane_n) wbeat_q <= 1'b1;
	end
	property p_we_oe; write_strobe_lane_oe == pin_fn_write_strobe; endproperty
	a_we_oe: assert property (p_we_oe) else $error("write strobe enable wrong");
	property p_addr_oe; mem_addr_oe == {{3{pin_fn_addr_hi}}, {(AW-3){1'b1}}}; endproperty
	a_addr_oe: assert property (p_addr_oe) else $error("address enable wrong");
	property p_bsz;
		bcr_rd |=> reg_rdata[10:9] == (strap_q ? AMSC_WIDTH_32 : AMSC_WIDTH_16);
	endproperty
	a_bsz: assert property (p_bsz) else $error("bus size not strapped");
	property p_endian; bcr_rd |=> !reg_rdata[AMSC_ENDIAN_BIT]; endproperty
	a_endian: assert property (p_endian) else $error("space zero not big endian");
	property p_bit0; !space_zero_select_n |-> !mem_addr[0]; endproperty
	a_bit0: assert property (p_bit0) else $error("address bit zero set");
	property p_setup;
		$fell(space_zero_select_n) && nrm && wcr_q[12:11] == 2'h1 |-> strb_n [*2] ##1 !strb_n;
	endproperty
	a_setup: assert property (p_setup) else $error("strobe setup wrong");
	property p_hold;
		$rose(strb_n) && nrm && wcr_q[1:0] == 2'h1
			|-> (!space_zero_select_n && strb_n && $stable(mem_addr)) [*2];
	endproperty
	a_hold: assert property (p_hold) else $error("strobe hold wrong");
	property p_rd_wait;
		$fell(read_strobe_n) && nrm && wcr_q[10:7] == 4'h6 && wcr_q[6]
			|-> !read_strobe_n [*7] ##1 read_strobe_n;
	endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
	property p_idle;
		$rose(space_zero_select_n) && wbeat_q && bcr_q[30:28] == 3'h2 |-> space_zero_select_n [*2];
	endproperty
	a_idle: assert property (p_idle) else $error("idle gap too short");
	property p_burst_edge;
		$fell(space_zero_select_n) && bcr_q[14:12] == AMSC_TYPE_BURST
			|-> read_strobe_n ##1 !read_strobe_n;
	endproperty
	a_burst_edge: assert property (p_burst_edge) else $error("burst edge wrong");
	// Data pins driven under a write strobe, released under a read strobe
	property p_doe; strb_n || (mem_data_oe == !write_strobe_lane_n); endproperty
	a_doe: assert property (p_doe) else $error("data drive wrong");
	c_burst: cover property ($fell(space_zero_select_n) && bcr_q[14:12] == AMSC_TYPE_BURST);
	c_write: cover property ($fell(write_strobe_lane_n));
	c_read: cover property ($fell(read_strobe_n) && nrm);
endmodule // amsc_ctrl_props

bind amsc_ctrl amsc_ctrl_props #(.AW(AW)) props_u (.clk(clk), .srst(srst),
	.boot_width_strap(boot_width_strap), .pin_fn_addr_hi(pin_fn_addr_hi),
	.pin_fn_write_strobe(pin_fn_write_strobe), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.space_zero_select_n(space_zero_select_n), .read_strobe_n(read_strobe_n),
	.write_strobe_lane_n(write_strobe_lane_n), .write_strobe_lane_oe(write_strobe_lane_oe),
	.mem_addr(mem_addr), .mem_addr_oe(mem_addr_oe), .mem_data_oe(mem_data_oe));
`default_nettype wire

//--- amsc_flash_model.sv
// Behavioural asynchronous flash on a 16-bit data bus
`default_nettype none
module amsc_flash_model #(
	parameter int AW = 24
) (
	// Control pins, active low
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic we_n,
	// Address and data
	input wire logic [AW-1:0] addr,
	input wire logic [15:0] din,
	output logic [15:0] dout
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] mem [0:255];
	logic [15:0] last_q = 16'h0000;
	// Word index starts at address bit one
	wire [7:0] widx = addr[8:1];
	always @(cs_n, rd_n, widx) if (!cs_n && !rd_n) last_q = mem[widx];
	// Released bus shows a changed level, never the last word
	assign dout = (!cs_n && !rd_n) ? mem[widx] : ~last_q;
	always @(posedge we_n) if (!cs_n) mem[widx] <= din;
endmodule // amsc_flash_model
`default_nettype wire

//--- amsc_ctrl_bench.sv
// Testbench of the memory space controller with a flash model
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; \
	$display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module amsc_ctrl_bench
	import amsc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic strap = 1'b0;
	logic pf_addr = 1'b0;
	logic pf_we = 1'b0;
	logic [31:0] reg_addr = 32'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic req_valid = 1'b0;
	logic req_write = 1'b0;
	logic [23:0] req_addr = 24'h0;
	logic [31:0] req_wdata = 32'h0;
	logic ext_wait = 1'b0;
	wire [31:0] reg_rdata, rsp_rdata, mem_data_o;
	wire [23:0] mem_addr, mem_addr_oe;
	wire [15:0] fl_q;
	wire req_ready, rsp_valid, cs_n, rd_n, we_n, we_oe, data_oe;
	int err_count = 0;
	int checks = 0;
	int lowc = 0;
	logic [31:0] q;
	always #20 clk = ~clk;
	always @(negedge clk) if (rd_n === 1'b0) lowc++;
	amsc_ctrl #(.SPACE_ID(0), .AW(24)) dut_u (.clk(clk), .srst(srst), .boot_width_strap(strap),
		.pin_fn_addr_hi(pf_addr), .pin_fn_write_strobe(pf_we), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.req_valid(req_valid), .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
		.req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
		.space_zero_select_n(cs_n), .read_strobe_n(rd_n), .write_strobe_lane_n(we_n),
		.write_strobe_lane_oe(we_oe), .mem_addr(mem_addr), .mem_addr_oe(mem_addr_oe),
		.mem_data_o(mem_data_o), .mem_data_oe(data_oe), .mem_data_i({16'h0000, fl_q}),
		.ext_wait_req(ext_wait));
	// Pins left as port pins float to their pull levels
	amsc_flash_model #(.AW(24)) flash_u (.cs_n(cs_n), .rd_n(rd_n), .we_n(we_oe ? we_n : 1'b1),
		.addr(mem_addr & mem_addr_oe), .din(mem_data_o[15:0]), .dout(fl_q));
	function automatic logic [15:0] pat(input int i);
		return {i[7:0], ~i[7:0]};
	endfunction
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic do_reset(input logic s);
		@(posedge clk);
		strap <= s;
		srst <= 1'b1;
		repeat (16) @(posedge clk);
		srst <= 1'b0;
	endtask
	task automatic reg_w(input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic reg_chk(input logic [31:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		`CHK(reg_rdata, e)
	endtask
	task automatic wait_rsp(output logic [31:0] r);
		int n;
		n = 0;
		do begin @(negedge clk); n++; end while (rsp_valid !== 1'b1 && n < 400);
		r = rsp_rdata;
		`CHK(rsp_valid, 1'b1)
	endtask
	task automatic acc(input logic w, input logic [23:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		@(posedge clk);
		req_valid <= 1'b1;
		req_write <= w;
		req_addr <= a;
		req_wdata <= d;
		n = 0;
		do begin @(negedge clk); n++; end while (req_ready !== 1'b1 && n < 100);
		@(posedge clk);
		req_valid <= 1'b0;
		wait_rsp(r);
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		$display("[FAIL] %0t watchdog expired", $time);
		err_count++;
		give_verdict();
	end
	initial begin
		for (int i = 0; i < 256; i++) flash_u.mem[i] = pat(i);
		do_reset(1'b0);
		reg_chk(AMSC_BCR_OFS, 32'h3000_0400);
		reg_chk(AMSC_WCR_OFS, AMSC_WCR_RST);
		reg_chk(32'hfffc_0008, 32'h0);
		$display("test reset values done");
		reg_w(AMSC_BCR_OFS, 32'h2000_0700);
		reg_w(AMSC_BCR_OFS, 32'h2000_2400);
		reg_w(32'hfffc_0008, 32'hffff_ffff);
		reg_chk(AMSC_BCR_OFS, 32'h2000_0400);
		reg_w(AMSC_WCR_OFS, 32'h0000_0b41);
		reg_chk(AMSC_WCR_OFS, 32'h0000_0b41);
		$display("test register access done");
		@(posedge clk);
		pf_addr <= 1'b1;
		pf_we <= 1'b1;
		ext_wait <= 1'b1;
		acc(1'b1, 24'h10, 32'h1234_abcd, q);
		acc(1'b1, 24'h14, 32'h5678_9abc, q);
		acc(1'b0, 24'h10, 32'h0, q);
		`CHK(q, 32'h1234_abcd)
		`CHK(flash_u.mem[8], 16'h1234)
		acc(1'b0, 24'h14, 32'h0, q);
		`CHK(q, 32'h5678_9abc)
		$display("test normal access done");
		// Burst timing first, kind last, and only while idle
		reg_w(AMSC_WCR_OFS, 32'h0013_03c0);
		reg_w(AMSC_BCR_OFS, 32'h2000_1400);
		reg_chk(AMSC_BCR_OFS, 32'h2000_1400);
		lowc = 0;
		acc(1'b0, 24'h40, 32'h0, q);
		`CHK(q, {pat(32), pat(33)})
		for (int k = 1; k < 4; k++) begin
			wait_rsp(q);
			`CHK(q, {pat(32 + 2 * k), pat(33 + 2 * k)})
		end
		for (int n = 0; n < 100 && cs_n !== 1'b1; n++) @(negedge clk);
		// First beat 8 waits plus strobe, seven later beats 3 waits plus strobe
		`CHK(lowc, (8 + 1) + 7 * (3 + 1))
		$display("test burst read done");
		do_reset(1'b1);
		reg_chk(AMSC_BCR_OFS, 32'h3000_0600);
		$display("test wide strap done");
		give_verdict();
	end
endmodule // amsc_ctrl_bench
`default_nettype wire
